// file: rtl/wwd_pkg.sv
// Constants and types for the window watchdog block
// Notes on behaviour
// - Config byte: irq7, window6:5, run4, period3:1, standby0
// - Interval irq at three quarters of period
// - Run enable starts counting at reset release
// - Restart while window closed forces reset
// - Overflow without valid restart forces reset
// - First restart after reset ignores window
// - Standby control zero means window fully open
// - Standby with control zero stops counter, and osc unless interval timer needs it
// - Standby control one keeps counting in standby
// - Full window accepts restart anywhere before overflow
// - Counting continues during flash self-programming
// - Counter wide enough for 65536 slow cycles
// - Counter clocked only by slow oscillator tick
// - Window fractions 50, 75, 100 percent
// - Only full-byte write of ACH restarts
// - Watchdog reset clears counter, sets reset flag
// - After standby stop, resume counting from zero
package wwd_pkg;
    localparam int          CNT_W          = 17;
    localparam logic [7:0]  RESTART_KEY    = 8'hAC;
    localparam logic [7:0]  CFG_DEFAULT    = 8'h00;
    // Register byte addresses
    localparam logic [7:0]  ADDR_CFG       = 8'hC0;
    localparam logic [7:0]  ADDR_RESTART   = 8'hC4;
    localparam logic [7:0]  ADDR_CAUSE     = 8'hC8;
    localparam logic [7:0]  ADDR_STATUS    = 8'hCC;
    // Config byte fields
    localparam int          BIT_IRQ_EN     = 7;
    localparam int          BIT_WIN_HI     = 6;
    localparam int          BIT_WIN_LO     = 5;
    localparam int          BIT_RUN        = 4;
    localparam int          BIT_PER_HI     = 3;
    localparam int          BIT_PER_LO     = 1;
    localparam int          BIT_STBY       = 0;
    localparam int          BIT_CAUSE_WDT  = 4;
    // Shortest period in slow cycles, doubled per code step
    localparam int          PERIOD_BASE_LOG2 = 9;
    // Window codes
    localparam logic [1:0]  WIN_50         = 2'h1;
    localparam logic [1:0]  WIN_75         = 2'h2;
    localparam logic [1:0]  WIN_100        = 2'h3;
    // Slow oscillator rate
    localparam int          SYS_HZ         = 10000000;
    localparam int          SLOW_HZ        = 15000;
    localparam int          SLOW_DIV       = SYS_HZ / SLOW_HZ;

    typedef enum logic [1:0] {WWD_IDLE, WWD_RUN, WWD_HALTED} wwd_state_t;
endpackage

// file: rtl/wwd_tick_gen.sv
// Slow oscillator tick divider for the watchdog
`timescale 1ns/10ps
`default_nettype none
module wwd_tick_gen
    import wwd_pkg::*;
#(
    parameter int DIV = SLOW_DIV
) (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic osc_on,
    output logic      tick
);
    initial begin
        if (DIV < 2 || DIV > 65536) $error("DIV must be 2 to 65536 for the 16-bit phase");
    end

    logic [15:0] div_r;
    logic [15:0] div_nxt;

    // Oscillator off holds phase at zero so it restarts cleanly
    always_comb begin
        div_nxt = div_r;
        if (!osc_on)
            div_nxt = '0;
        else if (div_r == 16'(DIV - 1))
            div_nxt = '0;
        else
            div_nxt = div_r + 16'h0001;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            div_r <= '0;
        else
            div_r <= div_nxt;
    end

    assign tick = osc_on && (div_r == 16'(DIV - 1));
endmodule
`default_nettype wire

// file: rtl/wwd_top.sv
// Window watchdog with classic Wishbone register slave
//
// The Wishbone slave port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module wwd_top
    import wwd_pkg::*;
#(
    parameter int        DIV     = SLOW_DIV,
    parameter logic [7:0] CFG_BYTE = CFG_DEFAULT
) (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic [7:0]  cfg_byte_i,
    input  wire logic        standby_req,
    input  wire logic        interval_timer_lsosc_select,
    output logic             interval_irq,
    output logic             wdt_reset_req,
    output logic             low_speed_osc_on
);
    initial begin
        if (DIV < 2) $error("DIV must be at least 2");
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration capture
    logic [7:0]  cfg_r;
    logic [7:0]  cfg_nxt;
    logic        cfg_loaded_r;
    logic        cfg_loaded_nxt;

    // Caught on the first edge after release, never under reset itself
    always_comb begin
        cfg_nxt        = cfg_r;
        cfg_loaded_nxt = 1'b1;
        if (!cfg_loaded_r)
            cfg_nxt = cfg_byte_i;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_r        <= CFG_BYTE;
            cfg_loaded_r <= 1'b0;
        end else begin
            cfg_r        <= cfg_nxt;
            cfg_loaded_r <= cfg_loaded_nxt;
        end
    end

    // Field decode
    logic       irq_en;
    logic [1:0] win_sel;
    logic       run_en;
    logic [2:0] per_sel;
    logic       stby_on;
    assign irq_en  = cfg_r[BIT_IRQ_EN];
    assign win_sel = {cfg_r[BIT_WIN_HI], cfg_r[BIT_WIN_LO]};
    assign run_en  = cfg_r[BIT_RUN];
    assign per_sel = cfg_r[BIT_PER_HI:BIT_PER_LO];
    assign stby_on = cfg_r[BIT_STBY];

    // Period length for a select code
    function automatic logic [CNT_W-1:0] period_of(input logic [2:0] code);
        period_of = CNT_W'(1) << (PERIOD_BASE_LOG2 + int'(code));
    endfunction

    logic [CNT_W-1:0] period;
    logic [CNT_W-1:0] three_q;
    logic [CNT_W-1:0] win_open_at;
    assign period  = period_of(per_sel);
    assign three_q = period - (period >> 2);

    // Count from which restarts are allowed
    always_comb begin
        win_open_at = '0;
        if (stby_on) begin
            unique case (win_sel)
                WIN_50:  win_open_at = period >> 1;
                WIN_75:  win_open_at = period >> 2;
                WIN_100: win_open_at = '0;
                default: win_open_at = period >> 1;         // Prohibited code, safe 50%
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus slave
    logic       acc;
    logic       ack_r;
    logic       ack_nxt;
    logic [31:0] rdat_r;
    logic [31:0] rdat_nxt;
    logic       wr_restart;
    logic       cause_r;
    logic       cause_nxt;
    logic       first_r;
    logic       first_nxt;
    wwd_state_t state_r;
    wwd_state_t state_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;

    assign acc        = wb_cyc_i && wb_stb_i && !ack_r;
    assign wr_restart = acc && wb_we_i && (wb_adr_i == ADDR_RESTART);

    // One-cycle registered answer; unmapped reads give zero
    always_comb begin
        ack_nxt  = acc;
        rdat_nxt = rdat_r;
        if (acc && !wb_we_i) begin
            unique case (wb_adr_i)
                ADDR_CFG:    rdat_nxt = {24'h000000, cfg_r};
                ADDR_CAUSE:  rdat_nxt = 32'(cause_r) << BIT_CAUSE_WDT;
                ADDR_STATUS: rdat_nxt = {13'h0000, first_r,
                                         state_r == WWD_HALTED, cnt_r};
                default:     rdat_nxt = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ack_r  <= 1'b0;
            rdat_r <= '0;
        end else begin
            ack_r  <= ack_nxt;
            rdat_r <= rdat_nxt;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdat_r;

    ////////////////////////////////////////////////////////////////////////
    // Slow tick and oscillator control
    logic osc_on;
    logic tick;

    // Oscillator only stops when nothing else needs it
    assign osc_on = (run_en && !(state_r == WWD_HALTED))
                    || interval_timer_lsosc_select;
    assign low_speed_osc_on = osc_on;

    wwd_tick_gen #(.DIV(DIV)) u_tick (
        .clk     (clk),
        .reset_n (reset_n),
        .osc_on  (osc_on),
        .tick    (tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // Counter, window check and reset generation
    logic bad_write;
    logic early;
    logic good_restart;
    logic overflow;
    logic wdt_fire;
    logic irq_r;
    logic irq_nxt;
    logic fire_r;
    logic fire_nxt;

    // A write with byte lane 0 selected and key value is the only restart;
    // lane 0 unselected or another value counts as a bad write
    assign bad_write    = wr_restart && (wb_sel_i[0] != 1'b1
                          || wb_dat_i[7:0] != RESTART_KEY);
    assign early        = wr_restart && !first_r && (cnt_r < win_open_at);
    assign good_restart = wr_restart && !bad_write && !early;
    assign overflow     = tick && (state_r == WWD_RUN)
                          && (cnt_r == period - CNT_W'(1));
    assign wdt_fire     = (state_r != WWD_IDLE) && (bad_write || early || overflow);

    // Flash programming has no input here: only standby with control zero pauses the count
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        first_nxt = first_r;
        irq_nxt   = 1'b0;
        fire_nxt  = wdt_fire;
        unique case (state_r)
            WWD_IDLE: begin
                if (cfg_loaded_r && run_en)
                    state_nxt = WWD_RUN;
            end
            WWD_RUN: begin
                if (wdt_fire) begin
                    cnt_nxt = '0;
                end else if (good_restart) begin
                    cnt_nxt   = '0;
                    first_nxt = 1'b0;
                end else if (standby_req && !stby_on) begin
                    state_nxt = WWD_HALTED;
                end else if (tick) begin
                    cnt_nxt = cnt_r + CNT_W'(1);
                    if (irq_en && cnt_nxt == three_q)
                        irq_nxt = 1'b1;
                end
            end
            WWD_HALTED: begin
                if (wdt_fire)
                    cnt_nxt = '0;
                else if (!standby_req) begin
                    state_nxt = WWD_RUN;
                    cnt_nxt   = '0;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= WWD_IDLE;
            cnt_r   <= '0;
            first_r <= 1'b1;
            irq_r   <= 1'b0;
            fire_r  <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            first_r <= first_nxt;
            irq_r   <= irq_nxt;
            fire_r  <= fire_nxt;
        end
    end

    assign interval_irq  = irq_r;
    assign wdt_reset_req = fire_r;

    // Cause flag lives on reset_n, so it survives only a watchdog
    // reset routed elsewhere; set wins, cleared by writing one
    always_comb begin
        cause_nxt = cause_r;
        if (acc && wb_we_i && wb_adr_i == ADDR_CAUSE && wb_sel_i[0]
            && wb_dat_i[BIT_CAUSE_WDT])
            cause_nxt = 1'b0;
        if (wdt_fire)
            cause_nxt = 1'b1;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            cause_r <= 1'b0;
        else
            cause_r <= cause_nxt;
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    property p_ovf_reset;
        @(posedge clk) disable iff (!reset_n)
        overflow |=> wdt_reset_req && cnt_r == '0;
    endproperty
    a_ovf_reset: assert property (p_ovf_reset) else $error("overflow no reset");

    property p_bad_key;
        @(posedge clk) disable iff (!reset_n)
        (wr_restart && state_r != WWD_IDLE && wb_dat_i[7:0] != RESTART_KEY)
        |=> wdt_reset_req;
    endproperty
    a_bad_key: assert property (p_bad_key) else $error("bad key not fired");

    property p_early;
        @(posedge clk) disable iff (!reset_n)
        (wr_restart && state_r == WWD_RUN && !first_r && cnt_r < win_open_at)
        |=> wdt_reset_req;
    endproperty
    a_early: assert property (p_early) else $error("early restart not fired");

    property p_first_ok;
        @(posedge clk) disable iff (!reset_n)
        (first_r && wr_restart && state_r == WWD_RUN && !bad_write && !overflow)
        |=> !wdt_reset_req && cnt_r == '0;
    endproperty
    a_first_ok: assert property (p_first_ok) else $error("first restart refused");

    property p_irq;
        @(posedge clk) disable iff (!reset_n)
        interval_irq |-> irq_en && cnt_r == three_q;
    endproperty
    a_irq: assert property (p_irq) else $error("irq at wrong count");

    property p_full_win;
        @(posedge clk) disable iff (!reset_n)
        (!stby_on && wr_restart && state_r == WWD_RUN && !bad_write && !overflow)
        |=> !wdt_reset_req;
    endproperty
    a_full_win: assert property (p_full_win) else $error("window not full");

    property p_halt_hold;
        @(posedge clk) disable iff (!reset_n)
        (state_r == WWD_HALTED && standby_req && !wdt_fire) |=> $stable(cnt_r);
    endproperty
    a_halt_hold: assert property (p_halt_hold) else $error("count moved in halt");

    property p_wake_zero;
        @(posedge clk) disable iff (!reset_n)
        (state_r == WWD_HALTED && !standby_req) |=> state_r == WWD_RUN && cnt_r == '0;
    endproperty
    a_wake_zero: assert property (p_wake_zero) else $error("wake not at zero");

    property p_cause;
        @(posedge clk) disable iff (!reset_n)
        wdt_reset_req |-> cause_r;
    endproperty
    a_cause: assert property (p_cause) else $error("cause flag not set");

    property p_start;
        @(posedge clk) disable iff (!reset_n)
        (state_r == WWD_IDLE && cfg_loaded_r && run_en) |=> state_r == WWD_RUN;
    endproperty
    a_start: assert property (p_start) else $error("no start");
endmodule
`default_nettype wire

// file: tb/wwd_cpu_model.sv
// Far-side CPU model: standby requests and slow-osc demand of the interval timer
`timescale 1ns/10ps
`default_nettype none
module wwd_cpu_model (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic sleep_cmd,
    input  wire logic keep_osc,
    output logic      standby_req,
    output logic      interval_timer_lsosc_select
);
    ////////////////////////////////////////////////////////////////
    // Standby level follows the bench command one edge later, like a HALT
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            standby_req                 <= 1'b0;
            interval_timer_lsosc_select <= 1'b0;
        end else begin
            standby_req                 <= sleep_cmd;
            interval_timer_lsosc_select <= keep_osc;
        end
    end
    // Restarts come from the bench task flow, never from an irq handler
endmodule
`default_nettype wire

// file: tb/window_watchdog_timer_tb.sv
// Self-checking bench for the window watchdog over classic Wishbone
`timescale 1ns/10ps
`default_nettype none
module window_watchdog_timer_tb;
    import wwd_pkg::*;
    logic        clk, reset_n, cyc, stb, we, sleep_cmd, keep_osc;
    logic [7:0]  adr, cfg;
    logic [3:0]  sel;
    logic [31:0] dat, rdat, q;
    logic        ack, irq, rreq, osc_on, stby, lsel;
    int          failures, cmp_count, n_rst, n_irq, cycles;

    wwd_cpu_model u_cpu (.clk(clk), .reset_n(reset_n), .sleep_cmd(sleep_cmd),
        .keep_osc(keep_osc), .standby_req(stby), .interval_timer_lsosc_select(lsel));
    wwd_top #(.DIV(4)) u_dut (.clk(clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .cfg_byte_i(cfg), .standby_req(stby),
        .interval_timer_lsosc_select(lsel), .interval_irq(irq), .wdt_reset_req(rreq),
        .low_speed_osc_on(osc_on));

    ////////////////////////////////////////////////////////////////
    // Clock, pulse counters and hang guard
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (rreq === 1'b1) n_rst++;
        if (irq === 1'b1) n_irq++;
        if (cycles == 40000) begin
            failures++;
            give_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////
    // Tasks
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= s;
        // Hold the request until ack is sampled high; the cycle guard ends a hang
        do @(posedge clk);
        while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0; stb <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    task automatic boot(input logic [7:0] c);
        @(posedge clk);
        reset_n <= 1'b0; cfg <= c; sleep_cmd <= 1'b0;
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        n_rst = 0; n_irq = 0;
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        reset_n = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; sel = 4'h0;
        dat = 32'h0; cfg = 8'h00; sleep_cmd = 1'b0; keep_osc = 1'b0;
        failures = 0; cmp_count = 0; cycles = 0; n_rst = 0; n_irq = 0;
        // Config latch, read-only byte, early restarts, window, bad keys
        boot(8'h31);
        wb(1'b0, ADDR_CFG, 32'h0, 4'hF); chk("cfg", q, 32'h31);
        wb(1'b1, ADDR_CFG, 32'hFF, 4'hF); cfg <= 8'hFF;
        wb(1'b0, ADDR_CFG, 32'h0, 4'hF); chk("cfg ro", q, 32'h31);
        wb(1'b0, ADDR_STATUS, 32'h0, 4'hF); chk("running", q[16:0] != 0, 1);
        wb(1'b1, ADDR_RESTART, 32'hAC, 4'h1); chk("first ok", n_rst, 0);
        wb(1'b1, ADDR_RESTART, 32'hAC, 4'h1); chk("closed", n_rst, 1);
        wb(1'b0, ADDR_CAUSE, 32'h0, 4'hF); chk("flag", q[4], 1'b1);
        wb(1'b0, ADDR_STATUS, 32'h0, 4'hF); chk("cnt clr", q[16:0] < 17'h8, 1);
        wb(1'b1, ADDR_CAUSE, 32'h10, 4'hF);
        wb(1'b0, ADDR_CAUSE, 32'h0, 4'hF); chk("flag w1c", q[4], 1'b0);
        repeat (1100) @(posedge clk);
        wb(1'b1, ADDR_RESTART, 32'hAC, 4'h1); chk("open", n_rst, 1);
        wb(1'b1, ADDR_RESTART, 32'h55, 4'h1); chk("bad key", n_rst, 2);
        wb(1'b1, ADDR_RESTART, 32'hAC, 4'h0); chk("bit op", n_rst, 3);
        wb(1'b0, 8'hD0, 32'h0, 4'hF); chk("unmapped", q, 32'h0);
        $display("test window done");
        // Interval irq at three quarters, then overflow
        boot(8'hB1);
        repeat (1650) @(posedge clk);
        chk("irq", n_irq, 1);
        chk("no ovf yet", n_rst, 0);
        repeat (500) @(posedge clk);
        chk("ovf", n_rst, 1);
        $display("test overflow done");
        // Standby control zero: full window, stop in standby, resume at zero
        boot(8'h30);
        wb(1'b1, ADDR_RESTART, 32'hAC, 4'h1);
        repeat (20) @(posedge clk);
        wb(1'b1, ADDR_RESTART, 32'hAC, 4'h1); chk("full win", n_rst, 0);
        repeat (200) @(posedge clk);
        sleep_cmd <= 1'b1;
        repeat (10) @(posedge clk);
        chk("osc off", osc_on, 1'b0);
        wb(1'b0, ADDR_STATUS, 32'h0, 4'hF); chk("halted", q[17], 1'b1);
        // Interval timer still wants the slow clock: osc runs, count stays stopped
        keep_osc <= 1'b1;
        repeat (3) @(posedge clk);
        chk("osc shared", osc_on, 1'b1);
        wb(1'b0, ADDR_STATUS, 32'h0, 4'hF); chk("still halted", q[17], 1'b1);
        keep_osc <= 1'b0;
        sleep_cmd <= 1'b0;
        repeat (10) @(posedge clk);
        wb(1'b0, ADDR_STATUS, 32'h0, 4'hF); chk("resume", q[16:0] < 17'h8, 1);
        $display("test standby stop done");
        // Standby control one keeps counting
        boot(8'h31);
        sleep_cmd <= 1'b1;
        repeat (100) @(posedge clk);
        chk("osc kept", osc_on, 1'b1);
        wb(1'b0, ADDR_STATUS, 32'h0, 4'hF); chk("counting", q[16:0] > 17'h14, 1);
        $display("test standby run done");
        // 75% window on the doubled period, then its later overflow
        boot(8'h53);
        wb(1'b1, ADDR_RESTART, 32'hAC, 4'h1);
        repeat (700) @(posedge clk);
        wb(1'b1, ADDR_RESTART, 32'hAC, 4'h1); chk("75 closed", n_rst, 1);
        repeat (1400) @(posedge clk);
        wb(1'b1, ADDR_RESTART, 32'hAC, 4'h1); chk("75 open", n_rst, 1);
        repeat (2300) @(posedge clk);
        chk("long period", n_rst, 1);
        repeat (2000) @(posedge clk);
        chk("long ovf", n_rst, 2);
        $display("test long period done");
        // Run enable clear: no osc, restarts ignored
        boot(8'h00);
        chk("osc idle", osc_on, 1'b0);
        wb(1'b1, ADDR_RESTART, 32'h55, 4'h1); chk("idle", n_rst, 0);
        $display("test disabled done");
        give_verdict();
    end
endmodule
`default_nettype wire
